// ---- core/mdio_master.sv ----
// Notes on behaviour
// - management clock is peripheral clock divided by a ratio from 4 to 128.
// - clock pin is output only; data pin is driven or sampled as bidirectional.
// - each frame carries a 5-bit phy address and a 5-bit register address.
// - software selects whether frames begin with a preamble or omit it.
// - configurable delay sets when data changes after the clock falls.
// - configurable point after the clock rises at which read data is sampled.
// - separate interrupts on write data sent and read data received.
module mdio_master (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mdc,
    output logic             mdio_o,
    output logic             mdio_oe_n,
    input  wire logic        mdio_i,
    output logic             irq
);
    mdio_pkg::cfg_type   cfg_q;
    mdio_pkg::cmd_type   cmd_q;
    mdio_pkg::state_type state_q;
    logic [7:0]  cnt_q;
    logic [5:0]  idx_q;
    logic [31:0] txsh_q;
    logic [15:0] rx_q;
    logic [15:0] rdata_q;
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic        sync1_q;
    logic        sync2_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        mdc_q;
    logic        mdio_o_q;
    logic        mdio_oe_n_q;
    logic        irq_q;

    // apb decode
    wire access    = psel && penable;
    wire commit    = access && pready_q;
    wire sel_ctrl  = paddr == mdio_pkg::OFF_CTRL;
    wire sel_cmd   = paddr == mdio_pkg::OFF_CMD;
    wire sel_rdata = paddr == mdio_pkg::OFF_RDATA;
    wire sel_stat  = paddr == mdio_pkg::OFF_STATUS;
    wire sel_mask  = paddr == mdio_pkg::OFF_MASK;
    wire mapped    = sel_ctrl || sel_cmd || sel_rdata || sel_stat || sel_mask;
    wire busy      = state_q == mdio_pkg::ST_FRAME;
    // command written while a frame runs is dropped, so a frame is never torn
    wire start     = commit && pwrite && sel_cmd && !busy;
    wire wr_ctrl   = commit && pwrite && sel_ctrl;
    wire wr_stat   = commit && pwrite && sel_stat;
    wire wr_mask   = commit && pwrite && sel_mask;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_ctrl) begin
            rd_mux = {7'h00, cfg_q};
        end else if (sel_cmd) begin
            rd_mux = {5'h00, cmd_q};
        end else if (sel_rdata) begin
            rd_mux = {15'h0000, busy, rdata_q};
        end else if (sel_stat) begin
            rd_mux = {30'h0000_0000, status_q};
        end else if (sel_mask) begin
            rd_mux = {30'h0000_0000, mask_q};
        end
    end

    // clock phase points; ratio clamped into the legal range
    wire [7:0] ratio   = (cfg_q.div < mdio_pkg::DIV_MIN) ? mdio_pkg::DIV_MIN :
                         (cfg_q.div > mdio_pkg::DIV_MAX) ? mdio_pkg::DIV_MAX : cfg_q.div;
    wire [7:0] half    = {1'b0, ratio[7:1]};
    wire [7:0] hi_len  = ratio - half;
    wire [7:0] out_pt  = (cfg_q.delay >= half) ? half - 8'h01 : cfg_q.delay;
    wire [7:0] samp_pt = half + ((cfg_q.capture >= hi_len) ? hi_len - 8'h01
                                                            : cfg_q.capture);
    wire       slot_end = busy && (cnt_q == ratio - 8'h01);
    wire       out_ev   = busy && (cnt_q == out_pt);
    wire       samp_ev  = busy && (cnt_q == samp_pt);
    wire       frame_end = slot_end && (idx_q == mdio_pkg::IDX_LAST);
    wire       in_pre   = idx_q < mdio_pkg::IDX_FRAME;
    // phy owns the line from turnaround onward in a read
    wire       release_line = cmd_q.rd && (idx_q >= mdio_pkg::IDX_TA);
    wire       mdc_d    = busy && (cnt_q >= half);
    wire [1:0] ev_set   = {frame_end && cmd_q.rd, frame_end && !cmd_q.rd};
    wire [5:0] idx_first = cfg_q.preamble ? mdio_pkg::IDX_PRE : mdio_pkg::IDX_FRAME;
    wire [31:0] tx_word = {mdio_pkg::START_PAT,
                           pwdata[26] ? mdio_pkg::OP_READ : mdio_pkg::OP_WRITE,
                           pwdata[25:16], mdio_pkg::TA_WRITE, pwdata[15:0]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= access && !pready_q;
            pslverr_q <= access && !pready_q && !mapped;
            prdata_q  <= (access && !pready_q && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q    <= mdio_pkg::CFG_RESET;
            mask_q   <= 2'h0;
            status_q <= 2'h0;
            irq_q    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                cfg_q <= pwdata[24:0];
            end
            if (wr_mask) begin
                mask_q <= pwdata[1:0];
            end
            // a new event wins over a clear in the same cycle
            status_q <= (status_q & ~(wr_stat ? pwdata[1:0] : 2'h0)) | ev_set;
            irq_q    <= |(status_q & mask_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= mdio_i;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= mdio_pkg::ST_IDLE;
            cmd_q   <= '0;
            cnt_q   <= 8'h00;
            idx_q   <= 6'h00;
            txsh_q  <= 32'h0000_0000;
        end else begin
            case (state_q)
                mdio_pkg::ST_IDLE: begin
                    if (start) begin
                        state_q <= mdio_pkg::ST_FRAME;
                        cmd_q   <= pwdata[26:0];
                        txsh_q  <= tx_word;
                        cnt_q   <= 8'h00;
                        idx_q   <= idx_first;
                    end
                end
                mdio_pkg::ST_FRAME: begin
                    cnt_q <= slot_end ? 8'h00 : cnt_q + 8'h01;
                    if (out_ev && !in_pre) begin
                        txsh_q <= {txsh_q[30:0], 1'b0};
                    end
                    if (slot_end) begin
                        idx_q <= idx_q + 6'h01;
                    end
                    if (frame_end) begin
                        state_q <= mdio_pkg::ST_IDLE;
                    end
                end
                default: state_q <= mdio_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdc_q       <= 1'b0;
            mdio_o_q    <= 1'b1;
            mdio_oe_n_q <= 1'b1;
            rx_q        <= 16'h0000;
            rdata_q     <= 16'h0000;
        end else begin
            mdc_q <= mdc_d;
            if (out_ev) begin
                mdio_o_q    <= in_pre ? 1'b1 : txsh_q[31];
                mdio_oe_n_q <= release_line;
            end else if (!busy) begin
                mdio_oe_n_q <= 1'b1;
            end
            if (samp_ev && cmd_q.rd && idx_q >= mdio_pkg::IDX_DATA) begin
                rx_q <= {rx_q[14:0], sync2_q};
            end
            if (frame_end && cmd_q.rd) begin
                // last bit may be sampled in the closing cycle of the frame
                rdata_q <= samp_ev ? {rx_q[14:0], sync2_q} : rx_q;
            end
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign mdc       = mdc_q;
    assign mdio_o    = mdio_o_q;
    assign mdio_oe_n = mdio_oe_n_q;
    assign irq       = irq_q;

    // helper: cycles since the last mdc rise, to check the divided period
    logic [7:0] rise_gap_q;
    logic       rise_seen_q;
    wire        rise_now = mdc_d && !mdc_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_gap_q  <= 8'h00;
            rise_seen_q <= 1'b0;
        end else begin
            if (rise_now) begin
                rise_gap_q <= 8'h00;
            end else if (rise_gap_q != 8'hFF) begin
                rise_gap_q <= rise_gap_q + 8'h01;
            end
            // first rise of a frame has no earlier rise to measure from
            rise_seen_q <= busy && (rise_seen_q || rise_now);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    mdc_high_min_a: assert property ($rose(mdc_q) |-> mdc_q ##1 mdc_q)
        else $error("mdc high phase shorter than two cycles");
    mdc_low_min_a: assert property ($fell(mdc_q) |-> !mdc_q ##1 !mdc_q)
        else $error("mdc low phase shorter than two cycles");
    idle_quiet_a: assert property (!busy [*2] |-> !mdc_q && mdio_oe_n_q)
        else $error("pins active while idle");
    read_release_a: assert property (busy && cmd_q.rd && idx_q >= mdio_pkg::IDX_DATA
                                      |-> mdio_oe_n_q)
        else $error("data line driven during read data phase");
    out_point_a: assert property ($changed(mdio_o_q) |-> $past(cnt_q) == $past(out_pt))
        else $error("data line changed off its output point");
    capture_pt_a: assert property ($changed(rx_q) |-> $past(samp_ev))
        else $error("read bit captured off its sampling point");
    wdone_flag_a: assert property (frame_end && !cmd_q.rd |=> status_q[mdio_pkg::ST_WDONE])
        else $error("write done flag not set");
    rdone_flag_a: assert property (frame_end && cmd_q.rd |=> status_q[mdio_pkg::ST_RDONE])
        else $error("read done flag not set");
    irq_level_a: assert property ((|(status_q & mask_q)) [*2] |-> irq_q)
        else $error("interrupt low with unmasked flag set");
    no_pre_a: assert property (start && !cfg_q.preamble |=> idx_q == mdio_pkg::IDX_FRAME)
        else $error("preamble sent although disabled");
    cmd_hold_a: assert property (busy && !frame_end |=> $stable(cmd_q))
        else $error("command changed during a frame");
    apb_wait_a: assert property (access && !pready_q |=> pready_q ##1 !pready_q)
        else $error("apb answer timing broken");
    pready_pulse_a: assert property (pready_q |=> !pready_q)
        else $error("pready longer than one cycle");
    prdata_idle_a: assert property (!pready_q |-> prdata_q == 32'h0000_0000)
        else $error("read data not zero outside answer");
    slverr_a: assert property (access && !pready_q && !mapped |=> pslverr_q)
        else $error("unmapped access without error");
    mdc_period_a: assert property (rise_now && rise_seen_q |-> rise_gap_q == ratio - 8'h01)
        else $error("mdc period differs from ratio");
    pre_start_a: assert property (start && cfg_q.preamble |=> idx_q == mdio_pkg::IDX_PRE)
        else $error("preamble skipped although enabled");
    pre_ones_a: assert property (out_ev && in_pre |=> mdio_o_q && !mdio_oe_n_q)
        else $error("preamble bit not a driven one");
    // frame field checks, one bit each
    start_zero_a: assert property (out_ev && idx_q == mdio_pkg::IDX_FRAME |=> !mdio_o_q)
        else $error("first start bit not zero");
    start_one_a: assert property (out_ev && idx_q == mdio_pkg::IDX_FRAME + 6'h01 |=> mdio_o_q)
        else $error("second start bit not one");
    op_bit_a: assert property (out_ev && idx_q == mdio_pkg::IDX_FRAME + 6'h02 |=> mdio_o_q == cmd_q.rd)
        else $error("opcode first bit wrong");
    phy_msb_a: assert property (out_ev && idx_q == mdio_pkg::IDX_FRAME + 6'h04 |=> mdio_o_q == cmd_q.phy[4])
        else $error("phy address msb wrong");
    reg_msb_a: assert property (out_ev && idx_q == mdio_pkg::IDX_FRAME + 6'h09 |=> mdio_o_q == cmd_q.regad[4])
        else $error("register address msb wrong");
    wr_ta_a: assert property (out_ev && !cmd_q.rd && idx_q == mdio_pkg::IDX_TA |=> mdio_o_q && !mdio_oe_n_q)
        else $error("write turnaround first bit wrong");
    wr_ta_zero_a: assert property (out_ev && !cmd_q.rd && idx_q == mdio_pkg::IDX_TA + 6'h01 |=> !mdio_o_q)
        else $error("write turnaround second bit wrong");
    rd_ta_a: assert property (out_ev && cmd_q.rd && idx_q == mdio_pkg::IDX_TA |=> mdio_oe_n_q)
        else $error("line not released at read turnaround");
    wdata_msb_a: assert property (out_ev && !cmd_q.rd && idx_q == mdio_pkg::IDX_DATA |=> mdio_o_q == cmd_q.wdata[15])
        else $error("write data msb wrong");
    write_drive_a: assert property (busy && !cmd_q.rd && idx_q > mdio_pkg::IDX_FRAME |-> !mdio_oe_n_q)
        else $error("line released during write frame");
    frame_stop_a: assert property (frame_end |=> !busy)
        else $error("frame ran past its last bit");
    status_hold_a: assert property (status_q[mdio_pkg::ST_WDONE] && !(wr_stat && pwdata[0]) |=> status_q[mdio_pkg::ST_WDONE])
        else $error("write done flag lost without clear");
    status_clear_a: assert property (wr_stat && pwdata[0] && !ev_set[0] |=> !status_q[mdio_pkg::ST_WDONE])
        else $error("write done flag not cleared");
    irq_low_a: assert property ((!(|(status_q & mask_q))) [*2] |-> !irq_q)
        else $error("interrupt high with no unmasked flag");

    read_frame_c: cover property (frame_end && cmd_q.rd);
    write_frame_c: cover property (frame_end && !cmd_q.rd && !cfg_q.preamble);
    irq_raise_c: cover property ($rose(irq_q));
    set_clear_c: cover property (wr_stat && |ev_set);
    long_ratio_c: cover property (rise_now && ratio == mdio_pkg::DIV_MAX);
endmodule

// ---- core/mdio_pkg.sv ----
package mdio_pkg;
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_CMD    = 8'h04;
    localparam logic [7:0]  OFF_RDATA  = 8'h08;
    localparam logic [7:0]  OFF_STATUS = 8'h0C;
    localparam logic [7:0]  OFF_MASK   = 8'h10;

    localparam logic [7:0]  DIV_MIN    = 8'h04;
    localparam logic [7:0]  DIV_MAX    = 8'h80;
    localparam logic [7:0]  DIV_RESET  = 8'h80;

    localparam logic [5:0]  IDX_PRE    = 6'h00;
    localparam logic [5:0]  IDX_FRAME  = 6'h20;
    localparam logic [5:0]  IDX_TA     = 6'h2E;
    localparam logic [5:0]  IDX_DATA   = 6'h30;
    localparam logic [5:0]  IDX_LAST   = 6'h3F;

    localparam logic [1:0]  START_PAT  = 2'h1;
    localparam logic [1:0]  OP_WRITE   = 2'h1;
    localparam logic [1:0]  OP_READ    = 2'h2;
    localparam logic [1:0]  TA_WRITE   = 2'h2;

    localparam int          ST_WDONE   = 0;
    localparam int          ST_RDONE   = 1;
    localparam int          RD_BUSY    = 16;

    typedef struct packed {
        logic       preamble;
        logic [7:0] capture;
        logic [7:0] delay;
        logic [7:0] div;
    } cfg_type;

    localparam cfg_type CFG_RESET = '{preamble: 1'b1, capture: 8'h00, delay: 8'h00,
                                      div: DIV_RESET};

    typedef struct packed {
        logic        rd;
        logic [4:0]  phy;
        logic [4:0]  regad;
        logic [15:0] wdata;
    } cmd_type;

    typedef enum logic {ST_IDLE, ST_FRAME} state_type;
endpackage

// ---- tb/phy_model.sv ----
module phy_model (
    input  wire logic        pclk,
    input  wire logic        mdc,
    input  wire logic        mdio_o,
    input  wire logic        mdio_oe_n,
    input  wire logic [15:0] resp,
    output logic             line,
    output logic [31:0]      got,
    output logic [7:0]       pre_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       act = 0, rd_op = 0, oe = 0, d = 0;
    logic [7:0] pcnt = 0;
    int         idx = 0;
    // released line floats high through the pull-up
    assign line = !mdio_oe_n ? mdio_o : (oe ? d : 1'b1);
    always @(posedge mdc) begin
        if (!act && !mdio_oe_n) begin
            if (line) pcnt <= pcnt + 8'h01;
            else begin
                act <= 1;
                idx <= 1;
                got <= 32'h0;
                pre_cnt <= pcnt;
                pcnt <= 0;
                rd_op <= 0;
            end
        end else if (act) begin
            got <= {got[30:0], line};
            idx <= idx + 1;
            if (idx == 3) rd_op <= ({got[0], line} == 2'b10);
            if (idx == 31) begin
                act <= 0;
            end
        end
    end
    // change on the falling edge so the whole high phase is stable
    always @(negedge mdc) begin
        if (act && rd_op && idx >= 15) begin
            oe <= 1;
            d <= (idx == 15) ? 1'b0 : resp[31-idx];
        end else begin
            // last bit held through its whole clock period, then released
            oe <= 0;
        end
    end
endmodule

// ---- tb/mdio_master_tb_top.sv ----
module mdio_master_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mdc_q = 0;
    logic [7:0]  paddr = 8'h00, pre_cnt, dv [6] = '{8'h03, 8'h04, 8'h09, 8'h80, 8'hC8, 8'h10};
    logic [31:0] pwdata = 32'h0, prdata, got, rd, x, cmd, period = 32'h0;
    logic [31:0] lfsr_q = 32'h0001_0DC0;
    logic [15:0] resp = 16'h0;
    logic        pready, pslverr, mdc, mdio_o, mdio_oe_n, irq, line, err, pre, rdop;
    logic [1:0]  mask;
    logic [5:0]  pre_set = 6'b010110, rd_set = 6'b101100;
    int          fail_count = 0, compares = 0, ccnt = 0, n;
    always #50 pclk = ~pclk;
    mdio_master mdio_master_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mdc(mdc), .mdio_o(mdio_o),
        .mdio_oe_n(mdio_oe_n), .mdio_i(line), .irq(irq));
    phy_model phy_model_inst (.pclk(pclk), .mdc(mdc), .mdio_o(mdio_o),
        .mdio_oe_n(mdio_oe_n), .resp(resp), .line(line), .got(got), .pre_cnt(pre_cnt));
    always @(posedge pclk) begin
        ccnt <= ccnt + 1;
        mdc_q <= mdc;
        if (mdc && !mdc_q) begin
            period <= ccnt + 1;
            ccnt <= 0;
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [31:0] clamp(input logic [7:0] v);
        return (v < 8'h04) ? 32'h4 : ((v > 8'h80) ? 32'h80 : {24'h0, v});
    endfunction
    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, mdio_pkg::OFF_CTRL, 0);
        cmp(rd, 32'h0100_0080);
        apb(0, mdio_pkg::OFF_MASK, 0);
        cmp(rd, 0);
        apb(0, mdio_pkg::OFF_STATUS, 0);
        cmp(rd, 0);
        apb(0, 8'h14, 0);
        cmp({31'h0, err}, 1);
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            x = lfsr_q;
            pre = pre_set[i];
            rdop = rd_set[i];
            mask = (i == 4) ? 2'h0 : 2'h3;
            resp <= x[31:16];
            cmd = {5'h0, rdop, x[20:16], x[25:21], x[15:0]};
            apb(1, mdio_pkg::OFF_MASK, {30'h0, mask});
            apb(1, mdio_pkg::OFF_CTRL, {7'h0, pre, 7'h0, x[26], 7'h0, x[27], dv[i]});
            apb(1, mdio_pkg::OFF_CMD, cmd);
            apb(1, mdio_pkg::OFF_CMD, ~cmd);
            n = 0;
            do begin
                apb(0, mdio_pkg::OFF_RDATA, 0);
                n++;
            end while (rd[16] !== 1'b0 && n < 4000);
            repeat (2) @(posedge pclk);
            cmp({31'h0, irq}, {31'h0, mask != 0});
            apb(0, mdio_pkg::OFF_STATUS, 0);
            cmp(rd, rdop ? 32'h2 : 32'h1);
            cmp(got, {2'b01, rdop ? 2'b10 : 2'b01, cmd[25:16], 2'b10, rdop ? x[31:16] : x[15:0]});
            cmp({24'h0, pre_cnt}, pre ? 32'h20 : 32'h0);
            cmp(period, clamp(dv[i]));
            if (rdop) begin
                apb(0, mdio_pkg::OFF_RDATA, 0);
                cmp(rd, {16'h0, x[31:16]});
            end
            apb(1, mdio_pkg::OFF_STATUS, 32'h3);
            repeat (2) @(posedge pclk);
            cmp({31'h0, irq}, 0);
        end
        summarize();
    end
endmodule
